/* File: common/cxc_pkg.sv */
// Purpose: constants and types for the core extended control block
// Assumes: one 64-bit control word, fields in the upper bits
// Notes:   lower bits [28:0] are held as plain storage only
package cxc_pkg;

  // ----------------------------------------------------------------
  // register word
  // ----------------------------------------------------------------
  localparam int CTL_W = 64;
  localparam logic [63:0] CTL_RESET = 64'hA000000B40543000;
  // writable bits; reserved holes read zero
  localparam logic [63:0] CTL_WMASK = 64'hFFF8CBFFFFFFFFFF;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MCW_LSB = 61;  // miss_correlation_way_limit
  localparam int IWP_LSB = 58;  // instruction_way_partition
  localparam int DWP_LSB = 55;  // data_way_partition
  localparam int VFT_BIT = 54;  // vm_filter_flush_threshold
  localparam int SPD_BIT = 53;  // splintered_page_alloc_disable
  localparam int CHD_BIT = 52;  // contiguous_hint_disable
  localparam int TPD_BIT = 51;  // translation_prefetch_disable
  localparam int L1A_BIT = 47;  // level_one_aggregation_disable
  localparam int PAD_BIT = 46;  // page_aggregation_disable
  localparam int FAD_BIT = 43;  // flush_allocate_downstream
  localparam int WPT_LSB = 40;  // walk_prefetch_target_level
  localparam int LPT_LSB = 38;  // loadstore_prefetch_target_level
  localparam int FPT_LSB = 36;  // fetch_prefetch_target_level
  localparam int CED_BIT = 35;  // clean_evict_data_enable
  localparam int EMS_BIT = 34;  // evict_message_suppress
  localparam int LAF_BIT = 33;  // load_atomic_forced_local
  localparam int AAL_BIT = 32;  // acquire_atomic_local
  localparam int SAL_BIT = 31;  // store_atomic_local
  localparam int RAL_BIT = 30;  // release_atomic_local
  localparam int LAL_BIT = 29;  // load_atomic_local

  // ----------------------------------------------------------------
  // field codes and counts
  // ----------------------------------------------------------------
  localparam logic [2:0] MCW_OFF = 3'h0;
  localparam logic [2:0] MCW_MIN_LEGAL = 3'h5;
  localparam logic [5:0] VMID_THR_LO = 6'h10;  // 16 allocations
  localparam logic [5:0] VMID_THR_HI = 6'h20;  // 32 allocations
  localparam logic [1:0] PFT_OFF = 2'h0;
  localparam logic [1:0] PFT_CONS = 2'h1;
  localparam logic [1:0] PFT_AGGR = 2'h2;
  localparam logic [1:0] PFT_ALWAYS = 2'h3;
  localparam logic [1:0] PFT_CONS_MIN = 2'h3;  // confidence needed
  localparam logic [1:0] PFT_AGGR_MIN = 2'h1;
  localparam int WAYS = 8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LN_INVALID = 2'h0, LN_UCLEAN = 2'h1, LN_SCLEAN = 2'h2, LN_UDIRTY = 2'h3
  } cxc_line_t;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_WRITEBACK = 3'h1, OP_WRITEBACK_FULL = 3'h2,
    OP_WRITE_EVICT_FULL = 3'h3, OP_WRITE_EVICT = 3'h4, OP_EVICT = 3'h5
  } cxc_op_t;
  typedef enum logic [1:0] {
    SRC_WALK = 2'h0, SRC_LOADSTORE = 2'h1, SRC_FETCH = 2'h2
  } cxc_src_t;
  typedef enum logic [1:0] {
    AT_LOAD = 2'h0, AT_STORE = 2'h1, AT_ACQUIRE = 2'h2, AT_RELEASE = 2'h3
  } cxc_atom_t;

endpackage : cxc_pkg

/* File: common/cxc_way_if.sv */
// Purpose: carries way partition fields and resulting way masks
// Assumes: eight L2 ways
// Notes:   decoder side is purely combinational
`timescale 1ns/1ps
interface cxc_way_if;
  logic [2:0] inst_part;  // ways held for fetch
  logic [2:0] data_part;  // ways held for data
  logic [7:0] inst_ways;  // ways fetch may allocate
  logic [7:0] data_ways;  // ways data may allocate
  modport dec (input inst_part, input data_part, output inst_ways, output data_ways);
  modport ctl (output inst_part, output data_part, input inst_ways, input data_ways);
endinterface : cxc_way_if

/* File: hw/cxc_way_part.sv */
// Purpose: turns the two partition fields into allocation masks
// Assumes: fetch claims from way 7 down, data from way 0 up
// Notes:   a way claimed by both sides drops out of both masks
`timescale 1ns/1ps
module cxc_way_part (
  // clock and reset, only for checks
  input wire logic clk,
  input wire logic resetn,
  // partition fields in, masks out
  cxc_way_if.dec w
);
  import cxc_pkg::*;

  logic [7:0] iclaim;  // ways reserved for fetch
  logic [7:0] dclaim;  // ways reserved for data

  // ----------------------------------------------------------------
  // per-way claim decode
  // ----------------------------------------------------------------
  for (genvar i = 0; i < WAYS; i++) begin : g_way
    assign iclaim[i] = (4'(i) + {1'b0, w.inst_part}) >= 4'h8;
    assign dclaim[i] = 4'(i) < {1'b0, w.data_part};
    assign w.inst_ways[i] = ~dclaim[i];
    assign w.data_ways[i] = ~iclaim[i];
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_inst_claim: assert property (@(posedge clk) disable iff (!resetn)
    $countones(iclaim) == w.inst_part) else $error("fetch claim count wrong");
  chk_data_claim: assert property (@(posedge clk) disable iff (!resetn)
    $countones(dclaim) == w.data_part) else $error("data claim count wrong");
  chk_way_overlap: assert property (@(posedge clk) disable iff (!resetn)
    ((iclaim & dclaim & (w.inst_ways | w.data_ways)) == 8'h00) &&
    ((~(iclaim | dclaim) & ~(w.inst_ways & w.data_ways)) == 8'h00))
    else $error("shared or double-claimed way mask wrong");

endmodule : cxc_way_part

/* File: hw/cxc_ctl.sv */
// Purpose: core extended control word and the policy it drives
// Assumes: all request inputs come from logic on clk
// Notes:   software is expected to write only while the core is idle
`timescale 1ns/1ps

//
// Function
// - 64-bit word, fixed reset value
// - way limit 000 off, 101-111 keep ways
// - fetch partition claims top n ways
// - data partition claims bottom n ways
// - free ways shared, doubly claimed unused
// - vm filter flush after 16 or 32
// - splintered page allocation may be blocked
// - contiguous hint may be ignored
// - translation prefetcher may be turned off
// - aggregation off in level one only
// - aggregation off everywhere
// - flush clear: no downstream allocation
// - flush set: allocate downstream with hint
// - walk prefetch target four levels
// - load-store prefetch target four levels
// - fetch prefetch target four levels
// - clean unique eviction may carry data
// - clean eviction messages may be suppressed
// - load atomics forced near by default
// - acquire atomics may fill once
// - store, release, load atomics may fill
module cxc_ctl (
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // system register access
  input wire logic reg_wr_en,
  input wire logic [63:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [63:0] reg_rdata,
  output logic reg_rd_valid,
  // cache way policy
  output logic cmc_enable,
  output logic [2:0] cmc_min_data_ways,
  output logic [7:0] inst_alloc_ways,
  output logic [7:0] data_alloc_ways,
  // translation policy
  input wire logic vmid_alloc_new,
  output logic vm_filter_flush,
  output logic splinter_alloc_allow,
  output logic contig_hint_use,
  output logic tlb_prefetch_enable,
  output logic l1_aggregation_enable,
  output logic l2_aggregation_enable,
  // set/way flush copyback
  input wire logic flush_valid,
  input wire cxc_pkg::cxc_line_t flush_state,
  output logic flush_op_valid,
  output cxc_pkg::cxc_op_t flush_op,
  output logic flush_alloc_hint,
  // capacity eviction
  input wire logic evict_valid,
  input wire cxc_pkg::cxc_line_t evict_state,
  output logic evict_op_valid,
  output cxc_pkg::cxc_op_t evict_op,
  // prefetch target decision
  input wire logic pft_req_valid,
  input wire cxc_pkg::cxc_src_t pft_req_src,
  input wire logic pft_req_cacheable,
  input wire logic [1:0] pft_req_conf,
  output logic pft_resp_valid,
  output logic pft_gen,
  // atomic placement
  input wire logic atom_valid,
  input wire cxc_pkg::cxc_atom_t atom_kind,
  input wire logic atom_line_excl,
  output logic atom_resp_valid,
  output logic atom_near,
  output logic atom_fill
);
  import cxc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [63:0] ctl_r;  // the control word
  logic [63:0] rdata_r;  // read answer
  logic rd_valid_r;  // read answer strobe
  logic [7:0] inst_ways_r;  // registered fetch mask
  logic [7:0] data_ways_r;  // registered data mask
  logic [5:0] vm_cnt_r;  // unique vm allocations seen
  logic vm_flush_r;  // flush pulse
  logic fl_valid_r;  // flush answer strobe
  cxc_op_t fl_op_r;  // flush message
  logic fl_hint_r;  // flush allocation hint
  logic ev_valid_r;  // eviction answer strobe
  cxc_op_t ev_op_r;  // eviction message
  logic pf_valid_r;  // prefetch answer strobe
  logic pf_gen_r;  // prefetch target decision
  logic at_valid_r;  // atomic answer strobe
  logic at_near_r;  // run near
  logic at_fill_r;  // may issue one fill
  logic wr_seen_r;  // any write since reset
  logic [5:0] vm_thr;  // active threshold
  cxc_op_t fl_op_nxt;
  logic fl_hint_nxt;
  cxc_op_t ev_op_nxt;
  logic [1:0] pf_lvl;  // level for the requester
  logic at_local;  // near-with-fill enabled

  cxc_way_if wif ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // prefetch target generation for one request
  function automatic logic pft_decide(input logic [1:0] lvl, input logic cach,
                                      input logic [1:0] conf);
    logic gen;
    gen = 1'b0;
    unique case (lvl)
      PFT_OFF: gen = 1'b0;
      PFT_CONS: gen = !cach || (conf >= PFT_CONS_MIN);
      PFT_AGGR: gen = !cach || (conf >= PFT_AGGR_MIN);
      PFT_ALWAYS: gen = 1'b1;
    endcase
    return gen;
  endfunction : pft_decide

  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  // reset value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl_r <= CTL_RESET;
    end else if (ce && reg_wr_en) begin
      ctl_r <= reg_wdata & CTL_WMASK;
    end
  end

  // read answer one cycle after the request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 64'h0000000000000000;
      rd_valid_r <= 1'b0;
    end else if (ce) begin
      rd_valid_r <= reg_rd_en;
      if (reg_rd_en) begin
        rdata_r <= ctl_r;
      end
    end
  end

  // marks that software has changed the word
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_seen_r <= 1'b0;
    end else if (ce && reg_wr_en) begin
      wr_seen_r <= 1'b1;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rd_valid = rd_valid_r;

  // ----------------------------------------------------------------
  // way policy
  // ----------------------------------------------------------------
  // reserved limit codes disable
  assign cmc_enable = ctl_r[MCW_LSB +: 3] >= MCW_MIN_LEGAL;
  assign cmc_min_data_ways = cmc_enable ? ctl_r[MCW_LSB +: 3] : MCW_OFF;

  assign wif.inst_part = ctl_r[IWP_LSB +: 3];
  assign wif.data_part = ctl_r[DWP_LSB +: 3];

  cxc_way_part u_way_part (
    .clk(clk),
    .resetn(resetn),
    .w(wif.dec)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      inst_ways_r <= 8'hFF;
      data_ways_r <= 8'hFF;
    end else if (ce) begin
      inst_ways_r <= wif.inst_ways;
      data_ways_r <= wif.data_ways;
    end
  end

  assign inst_alloc_ways = inst_ways_r;
  assign data_alloc_ways = data_ways_r;

  // ----------------------------------------------------------------
  // translation policy
  // ----------------------------------------------------------------
  // threshold select
  assign vm_thr = ctl_r[VFT_BIT] ? VMID_THR_HI : VMID_THR_LO;

  // counts allocations; >= catches a lowered threshold mid-count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vm_cnt_r <= 6'h00;
      vm_flush_r <= 1'b0;
    end else if (ce) begin
      vm_flush_r <= 1'b0;
      if (vmid_alloc_new) begin
        if (vm_cnt_r >= vm_thr - 6'h01) begin
          vm_cnt_r <= 6'h00;
          vm_flush_r <= 1'b1;
        end else begin
          vm_cnt_r <= vm_cnt_r + 6'h01;
        end
      end
    end
  end

  assign vm_filter_flush = vm_flush_r;
  assign splinter_alloc_allow = ~ctl_r[SPD_BIT];
  assign contig_hint_use = ~ctl_r[CHD_BIT];
  assign tlb_prefetch_enable = ~ctl_r[TPD_BIT];
  assign l1_aggregation_enable = ~ctl_r[L1A_BIT] & ~ctl_r[PAD_BIT];
  assign l2_aggregation_enable = ~ctl_r[PAD_BIT];

  // ----------------------------------------------------------------
  // flush and eviction messages
  // ----------------------------------------------------------------
  // choose the flush copyback message
  always_comb begin
    fl_op_nxt = OP_NONE;
    fl_hint_nxt = 1'b0;
    unique case (flush_state)
      LN_UDIRTY: begin
        fl_op_nxt = ctl_r[FAD_BIT] ? OP_WRITEBACK_FULL : OP_WRITEBACK;
        fl_hint_nxt = ctl_r[FAD_BIT];
      end
      LN_UCLEAN: begin
        fl_op_nxt = ctl_r[FAD_BIT] ? OP_WRITE_EVICT_FULL : OP_EVICT;
        fl_hint_nxt = ctl_r[FAD_BIT];
      end
      LN_SCLEAN: fl_op_nxt = OP_EVICT;
      LN_INVALID: fl_op_nxt = OP_NONE;
    endcase
  end

  // choose the capacity eviction message
  always_comb begin
    ev_op_nxt = OP_NONE;
    unique case (evict_state)
      LN_UDIRTY: ev_op_nxt = OP_WRITEBACK_FULL;
      LN_UCLEAN: begin
        if (ctl_r[CED_BIT]) begin
          ev_op_nxt = OP_WRITE_EVICT;
        end else begin
          ev_op_nxt = ctl_r[EMS_BIT] ? OP_NONE : OP_EVICT;
        end
      end
      LN_SCLEAN: ev_op_nxt = ctl_r[EMS_BIT] ? OP_NONE : OP_EVICT;
      LN_INVALID: ev_op_nxt = OP_NONE;
    endcase
  end

  // flush answer register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fl_valid_r <= 1'b0;
      fl_op_r <= OP_NONE;
      fl_hint_r <= 1'b0;
    end else if (ce) begin
      fl_valid_r <= flush_valid && (fl_op_nxt != OP_NONE);
      if (flush_valid) begin
        fl_op_r <= fl_op_nxt;
        fl_hint_r <= fl_hint_nxt;
      end
    end
  end

  // eviction answer register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ev_valid_r <= 1'b0;
      ev_op_r <= OP_NONE;
    end else if (ce) begin
      ev_valid_r <= evict_valid && (ev_op_nxt != OP_NONE);
      if (evict_valid) begin
        ev_op_r <= ev_op_nxt;
      end
    end
  end

  assign flush_op_valid = fl_valid_r;
  assign flush_op = fl_op_r;
  assign flush_alloc_hint = fl_hint_r;
  assign evict_op_valid = ev_valid_r;
  assign evict_op = ev_op_r;

  // ----------------------------------------------------------------
  // prefetch target
  // ----------------------------------------------------------------
  // level for walk, load-store or fetch requests
  always_comb begin
    unique case (pft_req_src)
      SRC_WALK: pf_lvl = ctl_r[WPT_LSB +: 2];
      SRC_LOADSTORE: pf_lvl = ctl_r[LPT_LSB +: 2];
      SRC_FETCH: pf_lvl = ctl_r[FPT_LSB +: 2];
      default: pf_lvl = PFT_OFF;
    endcase
  end

  // decision register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pf_valid_r <= 1'b0;
      pf_gen_r <= 1'b0;
    end else if (ce) begin
      pf_valid_r <= pft_req_valid;
      if (pft_req_valid) begin
        pf_gen_r <= pft_decide(pf_lvl, pft_req_cacheable, pft_req_conf);
      end
    end
  end

  assign pft_resp_valid = pf_valid_r;
  assign pft_gen = pf_gen_r;

  // ----------------------------------------------------------------
  // atomic placement
  // ----------------------------------------------------------------
  // per-kind near-with-fill enable; load also forced near
  always_comb begin
    unique case (atom_kind)
      AT_LOAD: at_local = ctl_r[LAF_BIT] | ctl_r[LAL_BIT];
      AT_STORE: at_local = ctl_r[SAL_BIT];
      AT_ACQUIRE: at_local = ctl_r[AAL_BIT];
      AT_RELEASE: at_local = ctl_r[RAL_BIT];
    endcase
  end

  // near if exclusive or fill allowed; fill only when missing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      at_valid_r <= 1'b0;
      at_near_r <= 1'b0;
      at_fill_r <= 1'b0;
    end else if (ce) begin
      at_valid_r <= atom_valid;
      if (atom_valid) begin
        at_near_r <= atom_line_excl | at_local;
        at_fill_r <= ~atom_line_excl & at_local;
      end
    end
  end

  assign atom_resp_valid = at_valid_r;
  assign atom_near = at_near_r;
  assign atom_fill = at_fill_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_vm_last;
    ce && vmid_alloc_new && (vm_cnt_r == vm_thr - 6'h01);
  endsequence

  chk_reset_word: assert property (
    !wr_seen_r |-> ctl_r == CTL_RESET) else $error("word differs from reset value");
  chk_reserved_zero: assert property (
    ce && reg_wr_en |=> (ctl_r & ~CTL_WMASK) == 64'h0000000000000000)
    else $error("reserved bits not zero");
  chk_read_back: assert property (
    ce && reg_rd_en |=> reg_rd_valid && reg_rdata == $past(ctl_r))
    else $error("read answer wrong");
  chk_way_limit: assert property (
    cmc_enable == (ctl_r[MCW_LSB +: 3] >= 3'h5) && (!cmc_enable || cmc_min_data_ways >= 3'h5))
    else $error("way limit decode wrong");
  chk_vm_flush: assert property (
    s_vm_last |=> vm_filter_flush ##1 (!vm_filter_flush || !$past(ce)))
    else $error("vm filter flush missing");
  chk_vm_early: assert property (
    vm_filter_flush |-> $past(vm_cnt_r) >= (ctl_r[VFT_BIT] ? 6'h1F : 6'h0F) || $past(reg_wr_en)
    || !$past(ce))
    else $error("vm filter flushed early");
  chk_flush_op: assert property (
    ce && flush_valid && flush_state == LN_UDIRTY && !ctl_r[FAD_BIT]
    |=> flush_op_valid && flush_op == OP_WRITEBACK && !flush_alloc_hint)
    else $error("flush writeback wrong");
  chk_flush_alloc: assert property (
    ce && flush_valid && flush_state == LN_UCLEAN && ctl_r[FAD_BIT]
    |=> flush_op == OP_WRITE_EVICT_FULL && flush_alloc_hint)
    else $error("flush write evict wrong");
  chk_evict_supp: assert property (
    ce && evict_valid && evict_state == LN_SCLEAN && ctl_r[EMS_BIT] |=> !evict_op_valid)
    else $error("evict not suppressed");
  chk_load_near: assert property (
    ce && atom_valid && atom_kind == AT_LOAD && ctl_r[LAF_BIT] |=> atom_resp_valid && atom_near)
    else $error("load atomic not near");
  chk_acq_far: assert property (
    ce && atom_valid && atom_kind == AT_ACQUIRE && !ctl_r[AAL_BIT] && !atom_line_excl
    |=> !atom_near && !atom_fill) else $error("acquire atomic not far");
  chk_pft_off: assert property (
    ce && pft_req_valid && pft_req_src == SRC_WALK && ctl_r[WPT_LSB +: 2] == 2'h0
    |=> pft_resp_valid && !pft_gen) else $error("walk prefetch target not off");

endmodule : cxc_ctl

/* File: bench/cxc_ctl_tb_top.sv */
// Purpose: self-checking bench for the core extended control word
// Assumes: answers are registered, out at the taking edge itself
// Notes:   inputs change on the falling edge only
`timescale 1ns/1ps
module cxc_ctl_tb_top;
  import cxc_pkg::*;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic clk, resetn, ce, reg_wr_en, reg_rd_en, reg_rd_valid, vmid_alloc_new, vm_filter_flush;
  logic [63:0] reg_wdata, reg_rdata, w;
  logic cmc_enable, splinter_alloc_allow, contig_hint_use, tlb_prefetch_enable;
  logic l1_aggregation_enable, l2_aggregation_enable;
  logic [2:0] cmc_min_data_ways, lim;
  logic [7:0] inst_alloc_ways, data_alloc_ways, ic, dc;
  logic flush_valid, flush_op_valid, flush_alloc_hint, evict_valid, evict_op_valid;
  cxc_line_t flush_state, evict_state;
  cxc_op_t flush_op, evict_op, fo, eo;
  logic pft_req_valid, pft_req_cacheable, pft_resp_valid, pft_gen, fv, fh, ev, loc;
  cxc_src_t pft_req_src;
  logic [1:0] pft_req_conf, lvl;
  logic atom_valid, atom_line_excl, atom_resp_valid, atom_near, atom_fill;
  cxc_atom_t atom_kind;
  int n_fail = 0;
  int comparisons = 0;

  // design under test
  cxc_ctl dut (.clk(clk), .resetn(resetn), .ce(ce), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .cmc_enable(cmc_enable), .cmc_min_data_ways(cmc_min_data_ways),
    .inst_alloc_ways(inst_alloc_ways), .data_alloc_ways(data_alloc_ways),
    .vmid_alloc_new(vmid_alloc_new), .vm_filter_flush(vm_filter_flush),
    .splinter_alloc_allow(splinter_alloc_allow), .contig_hint_use(contig_hint_use),
    .tlb_prefetch_enable(tlb_prefetch_enable), .l1_aggregation_enable(l1_aggregation_enable),
    .l2_aggregation_enable(l2_aggregation_enable), .flush_valid(flush_valid),
    .flush_state(flush_state), .flush_op_valid(flush_op_valid), .flush_op(flush_op),
    .flush_alloc_hint(flush_alloc_hint), .evict_valid(evict_valid), .evict_state(evict_state),
    .evict_op_valid(evict_op_valid), .evict_op(evict_op), .pft_req_valid(pft_req_valid),
    .pft_req_src(pft_req_src), .pft_req_cacheable(pft_req_cacheable),
    .pft_req_conf(pft_req_conf), .pft_resp_valid(pft_resp_valid), .pft_gen(pft_gen),
    .atom_valid(atom_valid), .atom_kind(atom_kind), .atom_line_excl(atom_line_excl),
    .atom_resp_valid(atom_resp_valid), .atom_near(atom_near), .atom_fill(atom_fill));

  // ------------------------------------------------------------
  // clock, closing report and watchdog
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic complete_run();
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  // hang guard, counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    complete_run();
  end

  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one taking edge, back at the falling edge
  task automatic tick();
    @(posedge clk);
    @(negedge clk);
  endtask : tick
  // write, then let decodes and masks settle
  // writes only when idle
  task automatic wr(input logic [63:0] d);
    reg_wr_en = 1'b1;
    reg_wdata = d;
    tick();
    reg_wr_en = 1'b0;
    tick();
    tick();
  endtask : wr
  // read answer one cycle on, valid for one cycle only
  task automatic rd(input logic [63:0] exp);
    reg_rd_en = 1'b1;
    tick();
    reg_rd_en = 1'b0;
    chk({reg_rd_valid, reg_rdata}, {1'b1, exp});
    tick();
    chk(reg_rd_valid, 1'b0);
  endtask : rd
  // n allocations back to back, flush only after the last
  task automatic vm_run(input int n);
    for (int i = 1; i <= n; i++) begin
      vmid_alloc_new = 1'b1;
      tick();
      chk(vm_filter_flush, i == n);
    end
    vmid_alloc_new = 1'b0;
    tick();
  endtask : vm_run

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {resetn, reg_wr_en, reg_rd_en, vmid_alloc_new, flush_valid, evict_valid} = '0;
    {pft_req_valid, pft_req_cacheable, atom_valid, atom_line_excl} = '0;
    {reg_wdata, pft_req_conf} = '0;
    ce = 1'b1;
    flush_state = LN_INVALID;
    evict_state = LN_INVALID;
    pft_req_src = SRC_WALK;
    atom_kind = AT_LOAD;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    chk({cmc_enable, cmc_min_data_ways, inst_alloc_ways, data_alloc_ways}, 20'hDFFFF);
    rd(CTL_RESET);
    vm_run(16);
    wr(CTL_RESET | (64'h1 << VFT_BIT));
    vm_run(32);
    wr('1);
    rd(CTL_WMASK);
    wr('0);
    // a write with the enable low is dropped
    ce = 1'b0;
    reg_wr_en = 1'b1;
    reg_wdata = '1;
    tick();
    ce = 1'b1;
    reg_wr_en = 1'b0;
    tick();
    rd(64'h0);
    for (int k = 0; k < 512; k++) begin
      w = '0;
      w[63:55] = k[8:0];
      {w[L1A_BIT], w[PAD_BIT], w[TPD_BIT], w[CHD_BIT], w[SPD_BIT]} = k[4:0];
      wr(w);
      lim = k[8:6];
      ic = ~(8'hFF >> k[5:3]);
      dc = ~(8'hFF << k[2:0]);
      chk({cmc_enable, cmc_min_data_ways}, {lim >= 3'h5, (lim >= 3'h5) ? lim : 3'h0});
      chk({inst_alloc_ways, data_alloc_ways}, {~dc, ~ic});
      chk({splinter_alloc_allow, contig_hint_use, tlb_prefetch_enable, l1_aggregation_enable,
        l2_aggregation_enable}, {~k[0], ~k[1], ~k[2], ~(k[3] | k[4]), ~k[3]});
      rd(w);
    end
    for (int m = 0; m < 8; m++) begin
      w = CTL_RESET;
      {w[EMS_BIT], w[CED_BIT], w[FAD_BIT]} = m[2:0];
      wr(w);
      for (int s = 0; s < 4; s++) begin
        {flush_valid, evict_valid} = 2'h3;
        flush_state = cxc_line_t'(s);
        evict_state = cxc_line_t'(s);
        tick();
        fv = s != 0;
        fh = m[0] && (s == 3 || s == 1);
        fo = (s == 3) ? (m[0] ? OP_WRITEBACK_FULL : OP_WRITEBACK) : OP_EVICT;
        fo = (s == 1 && m[0]) ? OP_WRITE_EVICT_FULL : fo;
        ev = s == 3 || (s == 1 && m[1]) || (s != 0 && !m[2]);
        eo = (s == 3) ? OP_WRITEBACK_FULL : ((s == 1 && m[1]) ? OP_WRITE_EVICT : OP_EVICT);
        chk({flush_op_valid, evict_op_valid}, {fv, ev});
        if (fv) chk({flush_op, flush_alloc_hint}, {fo, fh});
        if (ev) chk(evict_op, eo);
      end
      {flush_valid, evict_valid} = 2'h0;
    end
    for (int lv = 0; lv < 4; lv++) begin
      w = CTL_RESET;
      w[41:40] = lv[1:0];
      w[39:38] = lv[1:0] + 2'h1;
      w[37:36] = lv[1:0] + 2'h2;
      wr(w);
      for (int q = 0; q < 128; q++) begin
        pft_req_valid = 1'b1;
        pft_req_src = cxc_src_t'(q[4:3]);
        {pft_req_cacheable, pft_req_conf} = q[2:0];
        tick();
        lvl = lv[1:0] + q[4:3];
        loc = (lvl == 2'h3) || (lvl != 2'h0 && (!q[2] || ((lvl == 2'h1) ? q[1:0] == 2'h3
          : q[1:0] != 2'h0)));
        chk({pft_resp_valid, pft_gen}, {1'b1, q[4:3] != 2'h3 && loc});
      end
      pft_req_valid = 1'b0;
    end
    for (int a = 0; a < 32; a++) begin
      w = CTL_RESET;
      w[33:29] = a[4:0];
      wr(w);
      for (int q = 0; q < 8; q++) begin
        atom_valid = 1'b1;
        atom_kind = cxc_atom_t'(q[2:1]);
        atom_line_excl = q[0];
        tick();
        loc = (q[2:1] == 0) ? (a[4] | a[0]) : (q[2:1] == 1) ? a[2] : (q[2:1] == 2) ? a[3] : a[1];
        chk({atom_resp_valid, atom_near, atom_fill}, {1'b1, q[0] | loc, !q[0] & loc});
      end
      atom_valid = 1'b0;
    end
    tick();
    complete_run();
  end
endmodule : cxc_ctl_tb_top
